// ==== ccd_seq_pkg.sv ====
package ccd_seq_pkg;

  // Line and frame layout
  localparam int DARK_PIX_LEAD  = 4;
  localparam int ACTIVE_PIX     = 1024;
  localparam int DARK_PIX_TRAIL = 8;
  localparam int DARK_LINE_LEAD = 4;
  localparam int ACTIVE_LINES   = 1024;
  localparam int DARK_LINE_TRAIL = 4;
  localparam int PIX_PER_LINE   = DARK_PIX_LEAD + ACTIVE_PIX + DARK_PIX_TRAIL;
  localparam int LINES_PER_FRAME = DARK_LINE_LEAD + ACTIVE_LINES + DARK_LINE_TRAIL;

  // Timing
  localparam int CLK_PERIOD_PS  = 4000;
  localparam int HALF_H_NS      = 250;
  localparam int HALF_H_CYC     = (HALF_H_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int V_STEP_NS      = 8000;
  localparam int V_STEP_CYC     = (V_STEP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RST_PULSE_NS   = 40;
  localparam int RST_PULSE_CYC  = (RST_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int FLUSH_EXTRA    = 2;
  localparam int FIFO_DEPTH     = 8;
  localparam int SAMPLE_W       = 16;

  // Reset values
  localparam logic PHASE_RST = 1'b0;
  localparam logic SHUT_RST  = 1'b0;

  typedef struct packed {
    logic vertical_phase_a;
    logic vertical_phase_b;
    logic horizontal_phase_a;
    logic horizontal_phase_b;
    logic split_gate_first;
    logic split_gate_second;
    logic output_reset;
    logic shutter_open;
  } ccd_drive_t;

  typedef struct packed {
    logic [SAMPLE_W-1:0] value;
    logic                dark;
    logic                line_end;
    logic                frame_end;
  } pixel_word_t;

endpackage : ccd_seq_pkg

// ==== ccd_pixel_fifo.sv ====
`timescale 1ns/1ps
`default_nettype none
module ccd_pixel_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             i_clock,
  input  wire logic             i_reset_n,
  input  wire logic             i_in_valid,
  output var  logic             o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output var  logic             o_out_valid,
  input  wire logic             i_out_ready,
  output var  logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  initial
  begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("DEPTH must be a power of two");
  end
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0]      wr_r;
  logic [AW:0]      rd_r;
  logic             push;
  logic             pop;
  logic             full;
  logic             empty;
  assign full  = (wr_r[AW] != rd_r[AW]) && (wr_r[AW-1:0] == rd_r[AW-1:0]);
  assign empty = (wr_r == rd_r);
  assign push  = i_in_valid && !full;
  assign pop   = !empty && i_out_ready;
  assign o_in_ready  = !full;
  assign o_out_valid = !empty;
  assign o_out_data  = mem_r[rd_r[AW-1:0]];
  always_ff @(posedge i_clock)
  begin
    if (push) mem_r[wr_r[AW-1:0]] <= i_in_data;
  end
  always_ff @(posedge i_clock)
  begin
    if (!i_reset_n) wr_r <= '0;
    else if (push) wr_r <= wr_r + 1'b1;
  end
  always_ff @(posedge i_clock)
  begin
    if (!i_reset_n) rd_r <= '0;
    else if (pop) rd_r <= rd_r + 1'b1;
  end
endmodule : ccd_pixel_fifo
`default_nettype wire

// ==== ccd_frame_readout_sequencer.sv ====
// Contract
// - Both vertical phases low during exposure
// - Line transfer starts raising vertical phase A
// - Swap vertical phases: A low, B high
// - Second swap, then phase A low
// - Read line by complementary horizontal clocking
// - Pulse output reset after each sample
// - Repeat until all lines read
// - Wide range: second gate blocked, first follows
// - High gain: first gate blocked, second follows
// - Shutter closed during readout
`timescale 1ns/1ps
`default_nettype none
module ccd_frame_readout_sequencer
  import ccd_seq_pkg::*;
#(
  parameter int EXPOSE_CYC = 250000,
  parameter int PIX_LINE   = PIX_PER_LINE,
  parameter int LINES      = LINES_PER_FRAME
) (
  input  wire logic                i_clock,
  input  wire logic                i_reset_n,
  input  wire logic                i_start,
  input  wire logic                i_high_gain,
  input  wire logic [SAMPLE_W-1:0] i_adc_data,
  output var  logic                o_adc_strobe,
  output var  ccd_drive_t          o_drive,
  output var  logic                o_busy,
  output var  pixel_word_t         o_pix_data,
  output var  logic                o_pix_valid,
  input  wire logic                i_pix_ready
);
  initial
  begin
    if (EXPOSE_CYC < 1 || PIX_LINE < 1 || LINES < 1) $error("bad sequencer parameters");
  end

  typedef enum logic [3:0] {
    ST_IDLE, ST_EXPOSE, ST_VA, ST_VSWAP, ST_VSWAP2, ST_VEND,
    ST_HA, ST_HB, ST_SAMPLE, ST_RESET, ST_WAIT
  } state_t;

  state_t      state_r;
  logic [31:0] tmr_r;
  logic [15:0] pix_r;
  logic [15:0] line_r;
  ccd_drive_t  drv_r;
  logic        strobe_r;
  logic        hg_r;
  pixel_word_t word_r;
  logic        word_v_r;
  logic        fifo_ready;
  logic        tmr_done;
  logic        line_dark;
  logic        pix_dark;
  logic        last_pix;
  logic        last_line;

  assign tmr_done  = (tmr_r == 32'h0000_0000);
  assign last_pix  = (pix_r == 16'(PIX_LINE + FLUSH_EXTRA - 1));
  assign last_line = (line_r == 16'(LINES - 1));
  assign pix_dark  = (pix_r < 16'(DARK_PIX_LEAD)) || (pix_r >= 16'(DARK_PIX_LEAD + ACTIVE_PIX));
  assign line_dark = (line_r < 16'(DARK_LINE_LEAD))
                   || (line_r >= 16'(DARK_LINE_LEAD + ACTIVE_LINES));

  // Sequencer state, timer and counters
  always_ff @(posedge i_clock)
  begin
    if (!i_reset_n)
    begin
      state_r <= ST_IDLE;
      tmr_r   <= 32'h0000_0000;
      pix_r   <= 16'h0000;
      line_r  <= 16'h0000;
    end
    else if (!tmr_done && state_r != ST_IDLE && state_r != ST_WAIT)
    begin
      tmr_r <= tmr_r - 32'h0000_0001;
    end
    else
    begin
      case (state_r)
        ST_IDLE:
        begin
          if (i_start)
          begin
            state_r <= ST_EXPOSE;
            tmr_r   <= 32'(EXPOSE_CYC - 1);
            line_r  <= 16'h0000;
          end
        end
        ST_EXPOSE:
        begin
          state_r <= ST_VA;
          tmr_r   <= 32'(V_STEP_CYC - 1);
        end
        ST_VA:
        begin
          state_r <= ST_VSWAP;
          tmr_r   <= 32'(V_STEP_CYC - 1);
        end
        ST_VSWAP:
        begin
          state_r <= ST_VSWAP2;
          tmr_r   <= 32'(V_STEP_CYC - 1);
        end
        ST_VSWAP2:
        begin
          state_r <= ST_VEND;
          tmr_r   <= 32'(V_STEP_CYC - 1);
        end
        ST_VEND:
        begin
          state_r <= ST_HA;
          pix_r   <= 16'h0000;
          tmr_r   <= 32'(HALF_H_CYC - 1);
        end
        ST_HA:
        begin
          state_r <= ST_HB;
          tmr_r   <= 32'(HALF_H_CYC - 1);
        end
        ST_HB:
        begin
          state_r <= ST_SAMPLE;
        end
        ST_SAMPLE:
        begin
          state_r <= ST_RESET;
          tmr_r   <= 32'(RST_PULSE_CYC - 1);
        end
        ST_RESET:
        begin
          state_r <= ST_WAIT;
        end
        ST_WAIT:
        begin
          if (fifo_ready && !word_v_r)
          begin
            if (!last_pix)
            begin
              state_r <= ST_HA;
              pix_r   <= pix_r + 16'h0001;
              tmr_r   <= 32'(HALF_H_CYC - 1);
            end
            else if (!last_line)
            begin
              state_r <= ST_VA;
              line_r  <= line_r + 16'h0001;
              tmr_r   <= 32'(V_STEP_CYC - 1);
            end
            else
            begin
              state_r <= ST_IDLE;
            end
          end
        end
        default:
        begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Output selection is latched at frame start
  always_ff @(posedge i_clock)
  begin
    if (!i_reset_n) hg_r <= 1'b0;
    else if (state_r == ST_IDLE && i_start) hg_r <= i_high_gain;
  end

  // Pin drive levels
  always_ff @(posedge i_clock)
  begin
    if (!i_reset_n)
    begin
      drv_r <= '0;
    end
    else
    begin
      drv_r.vertical_phase_a <= (state_r == ST_VA) || (state_r == ST_VSWAP2);
      drv_r.vertical_phase_b <= (state_r == ST_VSWAP);
      drv_r.horizontal_phase_a <= (state_r != ST_HB) && (state_r != ST_IDLE) && (state_r != ST_EXPOSE);
      drv_r.horizontal_phase_b <= (state_r == ST_HB);
      drv_r.split_gate_first  <= !hg_r && (state_r == ST_HB);
      drv_r.split_gate_second <= hg_r && (state_r == ST_HB);
      drv_r.output_reset <= (state_r == ST_RESET);
      drv_r.shutter_open <= (state_r == ST_EXPOSE);
    end
  end

  // Sample strobe rises on the same edge that horizontal B falls
  always_ff @(posedge i_clock)
  begin
    if (!i_reset_n) strobe_r <= 1'b0;
    else strobe_r <= (state_r == ST_SAMPLE) && tmr_done;
  end

  // Captured sample toward the FIFO; flush pixels beyond the line are dropped
  always_ff @(posedge i_clock)
  begin
    if (!i_reset_n)
    begin
      word_r   <= '0;
      word_v_r <= 1'b0;
    end
    else if (state_r == ST_RESET && tmr_done && pix_r < 16'(PIX_LINE))
    begin
      word_r.value     <= i_adc_data;
      word_r.dark      <= pix_dark || line_dark;
      word_r.line_end  <= (pix_r == 16'(PIX_LINE - 1));
      word_r.frame_end <= (pix_r == 16'(PIX_LINE - 1)) && last_line;
      word_v_r         <= 1'b1;
    end
    else if (word_v_r && fifo_ready)
    begin
      word_v_r <= 1'b0;
    end
  end

  ccd_pixel_fifo #(
    .WIDTH ($bits(pixel_word_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_clock     (i_clock),
    .i_reset_n   (i_reset_n),
    .i_in_valid  (word_v_r),
    .o_in_ready  (fifo_ready),
    .i_in_data   (word_r),
    .o_out_valid (o_pix_valid),
    .i_out_ready (i_pix_ready),
    .o_out_data  (o_pix_data)
  );

  assign o_drive      = drv_r;
  assign o_adc_strobe = strobe_r;

  always_ff @(posedge i_clock)
  begin
    if (!i_reset_n) o_busy <= 1'b0;
    else o_busy <= (state_r != ST_IDLE);
  end
endmodule : ccd_frame_readout_sequencer
`default_nettype wire

// ==== ccd_seq_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
module ccd_seq_assertions
  import ccd_seq_pkg::*;
(
  input wire logic       i_clock,
  input wire logic       i_reset_n,
  input wire logic       o_adc_strobe,
  input wire ccd_drive_t o_drive,
  input wire logic       o_pix_valid,
  input wire logic       i_pix_ready
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_reset_n);
  logic [11:0] vb_cnt_r;
  always_ff @(posedge i_clock)
    vb_cnt_r <= (!i_reset_n || !o_drive.vertical_phase_b) ? 12'h000 : vb_cnt_r + 12'h001;
  AST_EXPOSE_LOW:
    assert property (o_drive.shutter_open |-> !o_drive.vertical_phase_a && !o_drive.vertical_phase_b)
    else $error("vertical phase high in exposure");
  AST_PHASE_A_FIRST:
    assert property ($rose(o_drive.vertical_phase_a) |-> !o_drive.vertical_phase_b)
    else $error("phase a rose with phase b high");
  AST_SWAP_ONE:
    assert property ($rose(o_drive.vertical_phase_b) |-> $fell(o_drive.vertical_phase_a))
    else $error("first swap broken");
  AST_SWAP_TWO:
    assert property ($fell(o_drive.vertical_phase_b) |-> $rose(o_drive.vertical_phase_a) && vb_cnt_r == V_STEP_CYC)
    else $error("second swap broken");
  AST_H_COMPL:
    assert property ((o_drive.horizontal_phase_a || o_drive.horizontal_phase_b) |->
      (o_drive.horizontal_phase_a != o_drive.horizontal_phase_b))
    else $error("horizontal clocks not complementary");
  AST_H_B_VERT_LOW:
    assert property (o_drive.horizontal_phase_b |-> !o_drive.vertical_phase_a && !o_drive.vertical_phase_b)
    else $error("horizontal phase b high during vertical step");
  AST_SPLIT:
    assert property (o_drive.horizontal_phase_b == (o_drive.split_gate_first | o_drive.split_gate_second)
      && !(o_drive.split_gate_first && o_drive.split_gate_second))
    else $error("split gate wrong");
  AST_STROBE:
    assert property ($fell(o_drive.horizontal_phase_b) |-> ##[0:3] o_adc_strobe)
    else $error("no sample strobe");
  AST_RESET_PULSE:
    assert property ($rose(o_drive.output_reset) |-> o_drive.output_reset[*8] ##1 o_drive.output_reset[*2]
      ##1 !o_drive.output_reset)
    else $error("output reset pulse length");
  AST_DARK_READ:
    assert property ((o_drive.vertical_phase_b || o_drive.horizontal_phase_b || o_drive.output_reset)
      |-> !o_drive.shutter_open)
    else $error("shutter open in readout");
  cover property ($rose(o_drive.vertical_phase_b));
  cover property ($fell(o_drive.horizontal_phase_b) && o_drive.split_gate_second);
  cover property (o_pix_valid && !i_pix_ready [*8]);
endmodule : ccd_seq_assertions
bind ccd_frame_readout_sequencer ccd_seq_assertions ccd_seq_assertions_i (.i_clock(i_clock),
  .i_reset_n(i_reset_n), .o_adc_strobe(o_adc_strobe), .o_drive(o_drive), .o_pix_valid(o_pix_valid),
  .i_pix_ready(i_pix_ready));
`default_nettype wire

// ==== ccd_sensor_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module ccd_sensor_model
  import ccd_seq_pkg::*;
(
  input  wire logic                i_clock,
  input  wire ccd_drive_t          i_drive,
  output var  logic [SAMPLE_W-1:0] o_adc_data
);
  ccd_drive_t prev_r;
  logic [7:0] line_r = 8'h00;
  logic [7:0] pix_r  = 8'h00;
  always_ff @(posedge i_clock)
    prev_r <= i_drive;
  // Line count restarts with each exposure
  always_ff @(posedge i_clock)
    if (i_drive.shutter_open)
      line_r <= 8'h00;
    else if (i_drive.vertical_phase_b && !prev_r.vertical_phase_b)
      line_r <= line_r + 8'h01;
  always_ff @(posedge i_clock)
    if (i_drive.vertical_phase_b && !prev_r.vertical_phase_b)
      pix_r <= 8'h00;
    else if (!i_drive.horizontal_phase_b && prev_r.horizontal_phase_b)
      pix_r <= pix_r + 8'h01;
  // Level is valid only while the node is being reset
  always_comb
    o_adc_data = i_drive.output_reset ? {line_r, pix_r} : ~{line_r, pix_r};
endmodule : ccd_sensor_model
`default_nettype wire

// ==== tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import ccd_seq_pkg::*;
;
  localparam int PL = 8;
  localparam int LN = 3;
  typedef struct packed {logic hg; logic [15:0] stall;} row_t;
  row_t        rows [2] = '{'{1'b0, 16'h0000}, '{1'b1, 16'h4E20}};
  logic        clock = 1'b0, reset_n = 1'b0, start = 1'b0, high_gain = 1'b0, pix_ready = 1'b0;
  logic        strobe, busy, pix_valid, seen_f, seen_s;
  logic [15:0] adc_data;
  ccd_drive_t  drive;
  pixel_word_t pix_word;
  int          err_total = 0, checks_done = 0, cyc = 0, strobe_cnt = 0;
  ccd_frame_readout_sequencer #(.EXPOSE_CYC(20), .PIX_LINE(PL), .LINES(LN)) ccd_frame_readout_sequencer_i (
    .i_clock(clock), .i_reset_n(reset_n), .i_start(start), .i_high_gain(high_gain), .i_adc_data(adc_data),
    .o_adc_strobe(strobe), .o_drive(drive), .o_busy(busy), .o_pix_data(pix_word), .o_pix_valid(pix_valid),
    .i_pix_ready(pix_ready));
  ccd_sensor_model ccd_sensor_model_i (.i_clock(clock), .i_drive(drive), .o_adc_data(adc_data));
  always #2 clock = ~clock;
  always @(posedge clock)
  begin
    if (drive.split_gate_first === 1'b1) seen_f <= 1'b1;
    if (drive.split_gate_second === 1'b1) seen_s <= 1'b1;
    if (strobe === 1'b1) strobe_cnt <= strobe_cnt + 1;
    cyc++;
    if (cyc == 90000)
    begin
      err_total++;
      complete_run();
    end
  end
  task check_eq(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check_eq
  task complete_run;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : complete_run
  task run_frame(input row_t r);
    int n;
    @(posedge clock);
    start <= 1'b1;
    high_gain <= r.hg;
    pix_ready <= (r.stall == 0);
    @(posedge clock);
    start <= 1'b0;
    seen_f = 1'b0;
    seen_s = 1'b0;
    strobe_cnt = 0;
    repeat (r.stall) @(posedge clock);
    @(posedge clock);
    @(negedge clock);
    check_eq("busy_run", busy, 1);
    if (r.stall != 0) check_eq("fifo_full_valid", pix_valid, 1);
    @(posedge clock);
    pix_ready <= 1'b1;
    for (int l = 0; l < LN; l++)
      for (int p = 0; p < PL; p++)
      begin
        n = 0;
        @(negedge clock);
        while (pix_valid !== 1'b1 && n < 20000)
        begin
          @(negedge clock);
          n++;
        end
        check_eq("value", pix_word.value, {8'(l + 1), 8'(p + 1)});
        check_eq("line_end", pix_word.line_end, p == PL - 1);
        check_eq("frame_end", pix_word.frame_end, l == LN - 1 && p == PL - 1);
        check_eq("dark", pix_word.dark, (p < DARK_PIX_LEAD) || (p >= DARK_PIX_LEAD + ACTIVE_PIX)
          || (l < DARK_LINE_LEAD) || (l >= DARK_LINE_LEAD + ACTIVE_LINES));
      end
    n = 0;
    while (busy !== 1'b0 && n < 20000)
    begin
      @(negedge clock);
      n++;
    end
    check_eq("busy", busy, 0);
    check_eq("drive", drive, 0);
    check_eq("gate_second", seen_s, r.hg);
    check_eq("gate_first", seen_f, !r.hg);
    check_eq("strobes", strobe_cnt, LN * (PL + FLUSH_EXTRA));
    $display("frame test done, high gain %0d", r.hg);
  endtask : run_frame
  initial
  begin
    repeat (20) @(posedge clock);
    reset_n <= 1'b1;
    for (int i = 0; i < 2; i++) run_frame(rows[i]);
    @(posedge clock);
    start <= 1'b1;
    @(posedge clock);
    start <= 1'b0;
    repeat (30) @(posedge clock);
    reset_n <= 1'b0;
    repeat (2) @(posedge clock);
    @(negedge clock);
    check_eq("reset_drive", drive, 0);
    check_eq("reset_busy", busy, 0);
    check_eq("reset_valid", pix_valid, 0);
    @(posedge clock);
    reset_n <= 1'b1;
    repeat (2) @(posedge clock);
    @(negedge clock);
    check_eq("release_drive", drive, 0);
    check_eq("release_busy", busy, 0);
    $display("reset test done");
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
